// ### common/eps_pkg.sv
// shared constants and types for the eeprom program/erase and security block
package eps_pkg;

    // ==================================================================
    // register map
    localparam logic [15:0] NV_PROGRAM_CONTROL_ADDR = 16'h103b;
    localparam logic [15:0] CFG_ADDR = 16'h103f;
    localparam logic [15:0] ARR_BASE = 16'hb600;
    localparam logic [15:0] ARR_LAST = 16'hb7ff;

    // ==================================================================
    // program control fields
    localparam int B_PGM = 0;
    localparam int B_LAT = 1;
    localparam int B_ERASE = 2;
    localparam int B_ROW = 3;
    localparam int B_BYTE = 4;
    localparam logic [7:0] NV_PROGRAM_CONTROL_RST = 8'h00;
    localparam logic [7:0] NV_PROGRAM_CONTROL_MASK = 8'hdf;
    localparam int SECURITY_DISABLE_BIT_BIT = 3;

    // ==================================================================
    // array geometry
    localparam int MEM_DEPTH = 513;
    localparam int MEM_AW = 10;
    localparam logic [9:0] CFG_IDX = 10'h200;
    localparam logic [8:0] IDX_LAST = 9'h1ff;
    localparam logic [8:0] ROW_MASK = 9'h00f;
    localparam logic [7:0] ERASED = 8'hff;

    // ==================================================================
    // types
    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_EXP,
        MODE_BOOT,
        MODE_TEST
    } mode_t;

    typedef enum logic [2:0] {
        ST_CHECK,
        ST_RUN,
        ST_WERASE,
        ST_WRAM,
        ST_WVER,
        ST_WCHK,
        ST_WCFG
    } st_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cpu_req_t;

endpackage

// ### logic/eps_mem.sv
// eeprom cell array plus configuration byte, registered read
`timescale 1ns/1ps
module eps_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 513,
    parameter int AW = 10
) (
    // clock
    input wire logic i_core_clk,
    // write port
    input wire logic i_we,
    input wire logic i_and,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    // read port
    input wire logic [AW-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rd_data,
    output logic [WIDTH-1:0] o_cfg
);

    // fresh part reads erased; set at declaration so the write process stays sole driver
    logic [WIDTH-1:0] mem [DEPTH] = '{default: '1};
    logic [WIDTH-1:0] rd_q;

    // ==================================================================
    // storage
    always_ff @(posedge i_core_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_and ? (mem[i_waddr] & i_wdata) : i_wdata;
        end
        rd_q <= mem[i_raddr];
    end

    assign o_rd_data = rd_q;
    assign o_cfg = mem[DEPTH-1];

endmodule // eps_mem

// ### logic/eps_mode.sv
// mode pin decode, security forcing and strobe pin direction
`timescale 1ns/1ps
module eps_mode #(
    parameter bit SEC_MASK = 1'b1
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // pins
    input wire logic i_mode_select_a_pin,
    input wire logic i_mode_select_b_pin,
    input wire logic i_strb_in,
    // core side
    input wire logic i_addr_strobe,
    input wire logic i_security_disable_bit,
    output eps_pkg::mode_t o_mode,
    output logic o_secure,
    output logic o_strb_out,
    output logic o_strb_oe,
    output logic o_strobe_a
);

    logic [2:0] s1_q;
    logic [2:0] s2_q;
    eps_pkg::mode_t mode_q, mode_d;
    logic sec_q, sec_d, eff_a, as_q;

    // ==================================================================
    // decode, captured while reset is held
    always_comb begin
        sec_d = SEC_MASK && !i_security_disable_bit;
        eff_a = s2_q[0] && !sec_d;
        case ({s2_q[1], eff_a})
            2'b11: mode_d = eps_pkg::MODE_EXP;
            2'b10: mode_d = eps_pkg::MODE_SINGLE;
            2'b00: mode_d = eps_pkg::MODE_BOOT;
            default: mode_d = eps_pkg::MODE_TEST;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        s1_q <= {i_strb_in, i_mode_select_b_pin, i_mode_select_a_pin};
        s2_q <= s1_q;
        as_q <= i_addr_strobe;
        if (i_rst) begin
            mode_q <= mode_d;
            sec_q <= sec_d;
        end
    end

    assign o_mode = mode_q;
    assign o_secure = sec_q;
    assign o_strb_oe = (mode_q == eps_pkg::MODE_EXP) || (mode_q == eps_pkg::MODE_TEST);
    assign o_strb_out = as_q;
    assign o_strobe_a = !o_strb_oe && s2_q[2];

    // ==================================================================
    // checks
    sec_force_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        sec_q |-> mode_q == eps_pkg::MODE_SINGLE || mode_q == eps_pkg::MODE_BOOT)
        else $error("secured part left single-chip modes");

    mode_exp_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $fell(i_rst) && $past(s2_q[1:0]) == 2'b11 && !sec_q |-> mode_q == eps_pkg::MODE_EXP)
        else $error("both mode pins high did not give expanded");

    strb_dir_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_secure |-> !o_strb_oe ##1 !o_strb_oe)
        else $error("strobe pin driven while secured");

endmodule // eps_mode

// ### logic/eps_ctrl.sv
// eeprom program/erase sequencing, register access and secured boot wipe
`timescale 1ns/1ps
module eps_ctrl #(
    parameter bit SEC_MASK = 1'b1
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // processor bus
    input wire eps_pkg::cpu_req_t i_req,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    // mode and strobe pins
    input wire logic i_mode_select_a_pin,
    input wire logic i_mode_select_b_pin,
    input wire logic i_strobe_or_addr_strobe_pin_in,
    output logic o_strobe_or_addr_strobe_pin_out,
    output logic o_strobe_or_addr_strobe_pin_oe,
    // core side
    input wire logic i_addr_strobe,
    output logic o_strobe_a,
    output eps_pkg::mode_t o_mode,
    output logic o_secure,
    // pump and boot wipe
    output logic o_high_voltage_on,
    output logic o_ram_wipe_req,
    input wire logic i_ram_wipe_done,
    input wire logic i_ram_wipe_ok,
    output logic o_download_go
);

    localparam int AW = eps_pkg::MEM_AW;

    logic [7:0] nv_program_control_q, nv_program_control_d;
    logic [8:0] lat_addr_q, lat_addr_d;
    logic lat_cfg_q, lat_cfg_d;
    logic [7:0] lat_data_q, lat_data_d;
    logic [8:0] idx_q, idx_d;
    eps_pkg::st_t st_q, st_d;
    logic fail_q, fail_d;
    logic ver_q, ver_d;
    logic go_q, go_d;
    logic pend_q, pend_d;
    logic msel_q, msel_d;
    logic val_q, val_d;
    logic [7:0] hold_q, hold_d;
    logic [7:0] rdat_q, rdat_d;
    logic mem_we, mem_and;
    logic [AW-1:0] mem_waddr, mem_raddr;
    logic [7:0] mem_wdata, mem_rd, cfg_byte;
    logic hit_pp, hit_cfg, hit_arr, run, mism;
    logic lat_on, pgm_on, ers_on, row_on, byte_on;
    logic [15:0] arr_off;
    eps_pkg::mode_t mode;
    logic secure;

    // ==================================================================
    // decode
    assign hit_pp = i_req.addr == eps_pkg::NV_PROGRAM_CONTROL_ADDR;
    assign hit_cfg = i_req.addr == eps_pkg::CFG_ADDR;
    assign hit_arr = i_req.addr >= eps_pkg::ARR_BASE && i_req.addr <= eps_pkg::ARR_LAST;
    assign arr_off = i_req.addr - eps_pkg::ARR_BASE;
    assign run = st_q == eps_pkg::ST_RUN;
    assign mism = ver_q && mem_rd != eps_pkg::ERASED;
    assign lat_on = nv_program_control_q[eps_pkg::B_LAT];
    assign pgm_on = nv_program_control_q[eps_pkg::B_PGM];
    assign ers_on = nv_program_control_q[eps_pkg::B_ERASE];
    assign row_on = nv_program_control_q[eps_pkg::B_ROW];
    assign byte_on = nv_program_control_q[eps_pkg::B_BYTE];

    // ==================================================================
    // program control register and latches
    always_comb begin
        nv_program_control_d = nv_program_control_q;
        lat_addr_d = lat_addr_q;
        lat_cfg_d = lat_cfg_q;
        lat_data_d = lat_data_q;
        if (run && i_req.we && hit_pp) begin
            nv_program_control_d = i_req.wdata & eps_pkg::NV_PROGRAM_CONTROL_MASK;
            if (nv_program_control_d[eps_pkg::B_PGM] && !lat_on) begin
                nv_program_control_d[eps_pkg::B_PGM] = 1'b0;
                nv_program_control_d[eps_pkg::B_LAT] = 1'b0;
            end
        end
        if (run && i_req.we && (hit_arr || hit_cfg) && lat_on && !pgm_on) begin
            lat_addr_d = arr_off[8:0];
            lat_cfg_d = hit_cfg;
            lat_data_d = i_req.wdata;
        end
    end

    // ==================================================================
    // array write port
    always_comb begin
        mem_we = 1'b0;
        mem_and = 1'b0;
        mem_waddr = {1'b0, idx_q};
        mem_wdata = eps_pkg::ERASED;
        mem_raddr = run ? {1'b0, arr_off[8:0]} : {1'b0, idx_q};
        case (st_q)
            eps_pkg::ST_RUN: begin
                if (pgm_on && !ers_on) begin
                    mem_we = 1'b1;
                    mem_and = 1'b1;
                    mem_wdata = lat_data_q;
                    mem_waddr = lat_cfg_q ? eps_pkg::CFG_IDX : {1'b0, lat_addr_q};
                end else if (pgm_on && byte_on) begin
                    mem_we = !lat_cfg_q;
                    mem_waddr = {1'b0, lat_addr_q};
                end else if (pgm_on && row_on) begin
                    mem_we = !lat_cfg_q;
                    mem_waddr = {1'b0, (lat_addr_q & ~eps_pkg::ROW_MASK)
                        | (idx_q & eps_pkg::ROW_MASK)};
                end else if (pgm_on) begin
                    mem_we = 1'b1;
                    mem_waddr = lat_cfg_q ? eps_pkg::CFG_IDX : {1'b0, idx_q};
                end
            end
            eps_pkg::ST_WERASE: begin
                mem_we = 1'b1;
            end
            eps_pkg::ST_WCFG: begin
                mem_we = 1'b1;
                mem_waddr = eps_pkg::CFG_IDX;
            end
            default: begin
                mem_we = 1'b0;
            end
        endcase
    end

    // ==================================================================
    // sweep and boot wipe sequencer
    always_comb begin
        st_d = st_q;
        idx_d = idx_q;
        fail_d = fail_q;
        ver_d = 1'b0;
        go_d = go_q;
        case (st_q)
            eps_pkg::ST_CHECK: begin
                if (mode == eps_pkg::MODE_BOOT && secure) begin
                    st_d = eps_pkg::ST_WERASE;
                    idx_d = '0;
                    fail_d = 1'b0;
                end else begin
                    st_d = eps_pkg::ST_RUN;
                    go_d = 1'b1;
                end
            end
            eps_pkg::ST_RUN: begin
                idx_d = pgm_on ? idx_q + 9'h001 : 9'h000;
            end
            eps_pkg::ST_WERASE: begin
                idx_d = idx_q + 9'h001;
                if (idx_q == eps_pkg::IDX_LAST) begin
                    st_d = eps_pkg::ST_WRAM;
                end
            end
            eps_pkg::ST_WRAM: begin
                if (i_ram_wipe_done) begin
                    st_d = eps_pkg::ST_WVER;
                    fail_d = !i_ram_wipe_ok;
                end
            end
            eps_pkg::ST_WVER: begin
                ver_d = 1'b1;
                idx_d = idx_q + 9'h001;
                if (mism) begin
                    fail_d = 1'b1;
                end
                if (idx_q == eps_pkg::IDX_LAST) begin
                    st_d = eps_pkg::ST_WCHK;
                end
            end
            eps_pkg::ST_WCHK: begin
                if (fail_q || mism) begin
                    st_d = eps_pkg::ST_WERASE;
                    fail_d = 1'b0;
                end else begin
                    st_d = eps_pkg::ST_WCFG;
                end
            end
            eps_pkg::ST_WCFG: begin
                st_d = eps_pkg::ST_RUN;
                go_d = 1'b1;
            end
            default: begin
                st_d = eps_pkg::ST_RUN;
            end
        endcase
    end

    // ==================================================================
    // read path, answer two edges after the request
    always_comb begin
        pend_d = run && i_req.re;
        msel_d = hit_arr && !lat_on;
        hold_d = hold_q;
        if (i_req.re) begin
            if (hit_pp) begin
                hold_d = nv_program_control_q;
            end else if (hit_cfg) begin
                hold_d = cfg_byte;
            end else begin
                hold_d = eps_pkg::ERASED;
            end
        end
        val_d = pend_q;
        rdat_d = rdat_q;
        if (pend_q) begin
            rdat_d = msel_q ? mem_rd : hold_q;
        end
    end

    // ==================================================================
    // registers
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            nv_program_control_q <= eps_pkg::NV_PROGRAM_CONTROL_RST;
            lat_addr_q <= '0;
            lat_cfg_q <= 1'b0;
            lat_data_q <= '0;
            idx_q <= '0;
            st_q <= eps_pkg::ST_CHECK;
            fail_q <= 1'b0;
            ver_q <= 1'b0;
            go_q <= 1'b0;
            pend_q <= 1'b0;
            msel_q <= 1'b0;
            val_q <= 1'b0;
            hold_q <= '0;
            rdat_q <= '0;
        end else begin
            nv_program_control_q <= nv_program_control_d;
            lat_addr_q <= lat_addr_d;
            lat_cfg_q <= lat_cfg_d;
            lat_data_q <= lat_data_d;
            idx_q <= idx_d;
            st_q <= st_d;
            fail_q <= fail_d;
            ver_q <= ver_d;
            go_q <= go_d;
            pend_q <= pend_d;
            msel_q <= msel_d;
            val_q <= val_d;
            hold_q <= hold_d;
            rdat_q <= rdat_d;
        end
    end

    assign o_rd_data = rdat_q;
    assign o_rd_valid = val_q;
    assign o_high_voltage_on = pgm_on;
    assign o_ram_wipe_req = st_q == eps_pkg::ST_WRAM;
    assign o_download_go = go_q;
    assign o_mode = mode;
    assign o_secure = secure;

    // ==================================================================
    // submodules
    eps_mem #(
        .WIDTH(8),
        .DEPTH(eps_pkg::MEM_DEPTH),
        .AW(AW)
    ) u_mem (
        .i_core_clk(i_core_clk),
        .i_we(mem_we),
        .i_and(mem_and),
        .i_waddr(mem_waddr),
        .i_wdata(mem_wdata),
        .i_raddr(mem_raddr),
        .o_rd_data(mem_rd),
        .o_cfg(cfg_byte)
    );

    eps_mode #(
        .SEC_MASK(SEC_MASK)
    ) u_mode (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_mode_select_a_pin(i_mode_select_a_pin),
        .i_mode_select_b_pin(i_mode_select_b_pin),
        .i_strb_in(i_strobe_or_addr_strobe_pin_in),
        .i_addr_strobe(i_addr_strobe),
        .i_security_disable_bit(cfg_byte[eps_pkg::SECURITY_DISABLE_BIT_BIT]),
        .o_mode(mode),
        .o_secure(secure),
        .o_strb_out(o_strobe_or_addr_strobe_pin_out),
        .o_strb_oe(o_strobe_or_addr_strobe_pin_oe),
        .o_strobe_a(o_strobe_a)
    );

    // ==================================================================
    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sequence wipe_end_s;
        st_q == eps_pkg::ST_WCFG && mem_we ##1 run && go_q;
    endsequence

    both_bits_a: assert property (
        run && i_req.we && hit_pp && i_req.wdata[1:0] == 2'b11 && !lat_on
        |=> !lat_on && !pgm_on)
        else $error("latch and voltage set in one write");

    hv_block_a: assert property (
        pgm_on && i_req.we && hit_arr |=> $stable(lat_addr_q) && $stable(lat_data_q))
        else $error("latched address or data moved under high voltage");

    prog_and_a: assert property (
        run && pgm_on && !ers_on |-> mem_we && mem_and && mem_wdata == lat_data_q)
        else $error("program cycle did not and latched data");

    row_sel_a: assert property (
        run && pgm_on && ers_on && row_on && !byte_on && mem_we
        |-> mem_waddr[8:4] == lat_addr_q[8:4])
        else $error("row erase left its row");

    bulk_cfg_a: assert property (
        run && pgm_on && ers_on && !row_on && !byte_on && !lat_cfg_q
        |-> mem_waddr != eps_pkg::CFG_IDX)
        else $error("bulk erase touched configuration byte");

    cfg_guard_a: assert property (
        run && mem_we && !mem_and && mem_waddr == eps_pkg::CFG_IDX
        |-> lat_cfg_q && !row_on && !byte_on)
        else $error("configuration byte erased outside bulk erase");

    wipe_done_a: assert property (
        st_q == eps_pkg::ST_WCHK && !fail_q && !mism |=> wipe_end_s)
        else $error("verified wipe did not release and start download");

    wipe_retry_a: assert property (
        st_q == eps_pkg::ST_WCHK && (fail_q || mism)
        |=> st_q == eps_pkg::ST_WERASE && idx_q == 9'h000)
        else $error("failed verify did not repeat the erase");

    hv_hold_a: assert property (
        pgm_on && !(i_req.we && hit_pp) |=> pgm_on)
        else $error("high voltage dropped without a register write");

endmodule // eps_ctrl

// ### tb/eps_ram_model.sv
// behavioural ram fill responder for the secured boot wipe
`timescale 1ns/1ps
module eps_ram_model #(
    parameter int LAT = 20,
    parameter int BAD = 1
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // fill handshake
    input wire logic i_wipe_req,
    output logic o_done,
    output logic o_ok,
    output int o_count
);
    // ==================================================================
    // fill sequencing
    int wait_q;
    logic busy_q;

    always_ff @(posedge i_core_clk) begin
        o_done <= 1'b0;
        o_ok <= ~o_ok;
        if (i_rst) begin
            busy_q <= 1'b0;
            wait_q <= 0;
            o_count <= 0;
            o_ok <= 1'b0;
        end else if (!i_wipe_req) begin
            busy_q <= 1'b0;
        end else if (!busy_q) begin
            busy_q <= 1'b1;
            wait_q <= LAT;
        end else if (wait_q != 0) begin
            wait_q <= wait_q - 1;
            if (wait_q == 1) begin
                o_done <= 1'b1;
                o_ok <= (o_count >= BAD);
                o_count <= o_count + 1;
            end
        end
    end
endmodule // eps_ram_model

// ### tb/eps_ctrl_test.sv
// self-checking bench for the eeprom program/erase and security block
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module eps_ctrl_test;
    // ==================================================================
    // signals
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    eps_pkg::cpu_req_t req = '0;
    logic pin_a = 1'b1, pin_b = 1'b1, strb_in = 1'b0, addr_strobe = 1'b0;
    logic [7:0] rd_data;
    logic rd_valid, strb_out, strb_oe, strobe_a, secure, hv_on, wipe_req, download_go;
    logic wipe_done, wipe_ok;
    eps_pkg::mode_t mode;
    int wipe_count, mismatches = 0, comparisons = 0;
    integer seed = 32'h45fc6e07;

    eps_ctrl u_eps_ctrl (.i_core_clk(core_clk), .i_rst(rst), .i_req(req),
        .o_rd_data(rd_data), .o_rd_valid(rd_valid), .i_mode_select_a_pin(pin_a),
        .i_mode_select_b_pin(pin_b), .i_strobe_or_addr_strobe_pin_in(strb_in),
        .o_strobe_or_addr_strobe_pin_out(strb_out), .o_strobe_or_addr_strobe_pin_oe(strb_oe),
        .i_addr_strobe(addr_strobe), .o_strobe_a(strobe_a), .o_mode(mode), .o_secure(secure),
        .o_high_voltage_on(hv_on), .o_ram_wipe_req(wipe_req), .i_ram_wipe_done(wipe_done),
        .i_ram_wipe_ok(wipe_ok), .o_download_go(download_go));
    eps_ram_model u_eps_ram_model (.i_core_clk(core_clk), .i_rst(rst), .i_wipe_req(wipe_req),
        .o_done(wipe_done), .o_ok(wipe_ok), .o_count(wipe_count));

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    // ==================================================================
    // bus tasks and expectations
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        req <= '0;
    endtask

    task automatic rd(input string n, input logic [15:0] a, input logic [7:0] e);
        @(posedge core_clk);
        req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        req <= '0;
        repeat (6) begin
            @(posedge core_clk);
            if (rd_valid === 1'b1) break;
        end
        `CHK("read valid", 1'b1, rd_valid)
        `CHK(n, e, rd_data)
    endtask

    task automatic op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d, input int t);
        wr(eps_pkg::NV_PROGRAM_CONTROL_ADDR, c);
        wr(a, d);
        wr(eps_pkg::NV_PROGRAM_CONTROL_ADDR, c | 8'h01);
        repeat (t) @(posedge core_clk);
        wr(eps_pkg::NV_PROGRAM_CONTROL_ADDR, 8'h00);
    endtask

    task automatic reset_to(input logic b, input logic a);
        pin_b <= b;
        pin_a <= a;
        rst <= 1'b1;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask

    function automatic eps_pkg::mode_t mode_of(input logic b, input logic a, input logic s);
        case ({b, a & ~s})
            2'b11: return eps_pkg::MODE_EXP;
            2'b10: return eps_pkg::MODE_SINGLE;
            2'b00: return eps_pkg::MODE_BOOT;
            default: return eps_pkg::MODE_TEST;
        endcase
    endfunction

    task automatic chk_mode(input logic b, input logic a, input logic s);
        eps_pkg::mode_t m;
        logic drv;
        m = mode_of(b, a, s);
        drv = (m == eps_pkg::MODE_EXP) || (m == eps_pkg::MODE_TEST);
        strb_in <= 1'b1;
        addr_strobe <= 1'b1;
        repeat (4) @(posedge core_clk);
        `CHK("mode", m, mode)
        `CHK("secure", s, secure)
        `CHK("strobe oe", drv, strb_oe)
        `CHK("strobe a", ~drv, strobe_a)
        if (drv) `CHK("strobe out", 1'b1, strb_out)
        strb_in <= 1'b0;
        addr_strobe <= 1'b0;
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ==================================================================
    // main sequence
    initial begin
        logic [15:0] a, x;
        logic [7:0] d1, d2;
        for (int i = 0; i < 4; i++) begin
            reset_to(i[1], i[0]);
            chk_mode(i[1], i[0], 1'b0);
        end
        a = eps_pkg::ARR_BASE + {7'h00, 9'($random(seed))};
        d1 = 8'($random(seed));
        d2 = 8'($random(seed));
        rd("erased", a, 8'hff);
        wr(eps_pkg::NV_PROGRAM_CONTROL_ADDR, 8'h02);
        wr(a, d1);
        wr(eps_pkg::NV_PROGRAM_CONTROL_ADDR, 8'h03);
        repeat (40) @(posedge core_clk);
        `CHK("hv on", 1'b1, hv_on)
        wr(a ^ 16'h0001, 8'h00);
        wr(eps_pkg::NV_PROGRAM_CONTROL_ADDR, 8'h00);
        repeat (3) @(posedge core_clk);
        `CHK("hv off", 1'b0, hv_on)
        rd("programmed", a, d1);
        rd("blocked", a ^ 16'h0001, 8'hff);
        op(8'h1a, a, d2, 40);
        rd("zeros only", a, d1 & d2);
        wr(eps_pkg::NV_PROGRAM_CONTROL_ADDR, 8'hff);
        rd("both bits", eps_pkg::NV_PROGRAM_CONTROL_ADDR, 8'hdc);
        wr(eps_pkg::NV_PROGRAM_CONTROL_ADDR, 8'h00);
        x = eps_pkg::ARR_BASE + {7'h00, 9'($random(seed)) & 9'h1f0};
        op(8'h02, x + 16'h0003, 8'h00, 40);
        op(8'h02, x ^ 16'h0010, 8'h00, 40);
        op(8'h0e, x + 16'h000c, 8'h55, 40);
        rd("row", x + 16'h0003, 8'hff);
        rd("next row", x ^ 16'h0010, 8'h00);
        for (int k = 0; k < 2; k++) begin
            op(8'h02, x, 8'h00, 40);
            op(8'h02, x + 16'h0001, 8'h00, 40);
            op(8'h16 | 8'(k << 3), x, 8'h00, 40);
            rd("byte", x, 8'hff);
            rd("neighbour", x + 16'h0001, 8'h00);
        end
        op(8'h02, eps_pkg::CFG_ADDR, 8'hf7, 40);
        rd("cfg prog", eps_pkg::CFG_ADDR, 8'hf7);
        op(8'h16, eps_pkg::CFG_ADDR, 8'h00, 40);
        rd("cfg byte erase", eps_pkg::CFG_ADDR, 8'hf7);
        op(8'h06, x, 8'h00, 600);
        rd("bulk", x + 16'h0001, 8'hff);
        rd("bulk", x ^ 16'h0010, 8'hff);
        rd("cfg kept", eps_pkg::CFG_ADDR, 8'hf7);
        op(8'h06, eps_pkg::CFG_ADDR, 8'h00, 600);
        rd("cfg erase", eps_pkg::CFG_ADDR, 8'hff);
        op(8'h02, eps_pkg::CFG_ADDR, 8'hf7, 40);
        op(8'h02, a, d1, 40);
        reset_to(1'b1, 1'b1);
        chk_mode(1'b1, 1'b1, 1'b1);
        rd("kept", a, d1);
        reset_to(1'b0, 1'b1);
        `CHK("boot", eps_pkg::MODE_BOOT, mode)
        for (int n = 0; n < 5000 && download_go !== 1'b1; n++) @(posedge core_clk);
        `CHK("go", 1'b1, download_go)
        `CHK("fills", 2, wipe_count)
        `CHK("wipe idle", 1'b0, wipe_req)
        rd("wiped", a, 8'hff);
        rd("released", eps_pkg::CFG_ADDR, 8'hff);
        reset_to(1'b1, 1'b1);
        chk_mode(1'b1, 1'b1, 1'b0);
        results();
    end

    initial begin
        repeat (40000) @(posedge core_clk);
        mismatches++;
        results();
    end
endmodule // eps_ctrl_test
